// ---- hw/adc_ctrl_pkg.sv ----
// adc_ctrl_pkg: register map, field positions, reset values and types
// for the converter control block.
// assumes a 32-bit APB bus with byte addresses on an 8-bit offset.
package adc_ctrl_pkg;

    // register offsets (byte addresses)
    localparam logic [7:0] OFF_CTRL0 = 8'h00;
    localparam logic [7:0] OFF_CTRL1 = 8'h04;
    localparam logic [7:0] OFF_CTRL2 = 8'h08;
    localparam logic [7:0] OFF_RES_HI = 8'h0c;
    localparam logic [7:0] OFF_RES_LO = 8'h10;
    localparam logic [7:0] OFF_AUTO = 8'h14;

    // adc_ctrl0_start_channel fields
    localparam int C0_START = 7;
    localparam int C0_BUSY = 6;
    localparam int C0_EN = 5;
    localparam int C0_FMT = 4;
    localparam int C0_CH_MSB = 3;

    // adc_ctrl1_input_ref_clock fields
    localparam int C1_INS_MSB = 7;
    localparam int C1_INS_LSB = 5;
    localparam int C1_REF_MSB = 4;
    localparam int C1_REF_LSB = 3;
    localparam int C1_CKS_MSB = 2;

    // adc_ctrl2_trigger_count fields
    localparam int C2_TSRC_MSB = 7;
    localparam int C2_TSRC_LSB = 6;
    localparam int C2_RPT = 4;
    localparam int C2_CNT_MSB = 2;

    // auto control fields
    localparam int AU_START = 0;
    localparam int AU_TWO = 1;

    // reset values
    localparam logic [7:0] RST_CTRL0 = 8'h00;
    localparam logic [7:0] RST_CTRL1 = 8'h00;
    localparam logic [7:0] RST_CTRL2 = 8'h00;
    localparam logic [7:0] RST_RES = 8'h00;

    // highest routed external channel code
    localparam logic [3:0] EXT_CH_LAST = 4'ha;

    typedef enum logic {CONV_IDLE, CONV_RUN} conv_state_e;

    typedef enum logic [1:0] {
        SIG_BANDGAP, SIG_AMP_A, SIG_AMP_B, SIG_VSS
    } int_sig_e;

    typedef enum logic [1:0] {
        TRG_PWM, TRG_TMR_OVP, TRG_TMR_SW, TRG_SW
    } trig_src_e;

    // analog switch controls towards the converter front end
    typedef struct packed {
        logic ext_on;
        logic [3:0] ext_ch;
        logic int_on;
        int_sig_e int_sig;
        logic ref_int;
    } analog_sel_s;

    // complete state of the control block
    typedef struct packed {
        conv_state_e conv;
        logic start;
        logic en;
        logic fmt;
        logic [3:0] ch;
        logic [7:0] ctrl1;
        logic [1:0] tsrc;
        logic rpt;
        logic [2:0] cnt;
        logic auto_st;
        logic two;
        logic [7:0] rhi;
        logic [7:0] rlo;
        logic [6:0] div;
        logic tick;
        logic go;
        logic tstart;
        logic pwm_p;
        logic ovp_p;
        logic [5:0] done_n;
        logic ch2;
        logic [31:0] rdata;
    } state_s;

endpackage

// ---- hw/adc_ctrl.sv ----
// adc_ctrl: control registers, start logic, busy flag, input routing,
// reference and clock selection and auto-trigger logic of one converter.
// assumes an APB master, an analog converter answering start with a
// done pulse plus data, and trigger inputs synchronous to REF_CLK_I.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module adc_ctrl
    import adc_ctrl_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic CLK_EN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic ADC_PWR_O,
    output logic ADC_START_O,
    input wire logic ADC_DONE_I,
    input wire logic [11:0] ADC_DATA_I,
    output logic CONV_CLK_TICK_O,
    input wire logic PWM_CH0_I,
    input wire logic OVP_CMP_I,
    input wire logic TIMER_OVF_I,
    output logic TIMER_START_O,
    input wire logic [4:0] CH1_SEL_I,
    input wire logic [4:0] CH2_SEL_I,
    output analog_sel_s ANALOG_SEL_O,
    output logic [10:0] PIN_ANALOG_O
);

    // group size for a count code
    function automatic logic [5:0] group_size(input logic [2:0] c);
        case (c)
            3'h0: group_size = 6'h00;
            3'h1: group_size = 6'h01;
            3'h2: group_size = 6'h02;
            3'h3: group_size = 6'h04;
            3'h4: group_size = 6'h08;
            default: group_size = 6'h10;
        endcase
    endfunction

    // divider mask for a clock select code
    function automatic logic [6:0] div_mask(input logic [2:0] c);
        div_mask = 7'(({7'h00, 1'b1} << c) - 8'h01);
    endfunction

    // internal signal for a channel select input code
    function automatic int_sig_e chan_int(input logic [3:0] c);
        case (c)
            4'h1: chan_int = SIG_AMP_A;
            4'h2: chan_int = SIG_AMP_B;
            4'h3: chan_int = SIG_VSS;
            default: chan_int = SIG_BANDGAP;
        endcase
    endfunction

    state_s q;
    state_s n;
    logic acc;
    logic wr;
    logic rd_setup;
    logic hit_c0, hit_c1, hit_c2, hit_hi, hit_lo, hit_au, mapped;
    logic wr_c0, wr_c1, wr_c2, wr_au;
    logic auto_mode, two_mode, busy;
    logic pwm_rise, ovp_rise, as_rise, start_fall;
    logic manual_go, trig, auto_go, rpt_set, conv_done, grp_end;
    logic [5:0] target;
    logic [4:0] chan_sel;
    logic [2:0] ins;
    logic int_pick;
    analog_sel_s asel;

    assign acc = PSEL_I & PENABLE_I;
    assign wr = acc & PWRITE_I & PSTRB_I[0];
    assign rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I;

    // address decode
    always_comb
    begin
        hit_c0 = 1'b0;
        hit_c1 = 1'b0;
        hit_c2 = 1'b0;
        hit_hi = 1'b0;
        hit_lo = 1'b0;
        hit_au = 1'b0;
        if (PADDR_I == OFF_CTRL0)
            hit_c0 = 1'b1;
        else if (PADDR_I == OFF_CTRL1)
            hit_c1 = 1'b1;
        else if (PADDR_I == OFF_CTRL2)
            hit_c2 = 1'b1;
        else if (PADDR_I == OFF_RES_HI)
            hit_hi = 1'b1;
        else if (PADDR_I == OFF_RES_LO)
            hit_lo = 1'b1;
        else if (PADDR_I == OFF_AUTO)
            hit_au = 1'b1;
    end

    assign mapped = hit_c0 | hit_c1 | hit_c2 | hit_hi | hit_lo | hit_au;
    assign wr_c0 = wr & hit_c0;
    assign wr_c1 = wr & hit_c1;
    assign wr_c2 = wr & hit_c2;
    assign wr_au = wr & hit_au;

    // mode decode
    assign auto_mode = q.cnt != 3'h0;
    assign two_mode = auto_mode & q.two;
    assign busy = q.conv == CONV_RUN;
    assign target = two_mode ? 6'(group_size(q.cnt) << 1)
                             : group_size(q.cnt);

    assign pwm_rise = PWM_CH0_I & ~q.pwm_p;
    assign ovp_rise = OVP_CMP_I & ~q.ovp_p;
    assign as_rise = wr_au & PWDATA_I[AU_START] & ~q.auto_st;

    // manual start on the falling half of the start pulse
    assign start_fall = wr_c0 & q.start & ~PWDATA_I[C0_START];
    assign manual_go = ~auto_mode & start_fall & q.en & ~busy;

    // trigger source selection
    always_comb
    begin
        trig = 1'b0;
        case (trig_src_e'(q.tsrc))
            TRG_PWM: trig = pwm_rise & q.auto_st;
            TRG_TMR_OVP: trig = TIMER_OVF_I & q.auto_st;
            TRG_TMR_SW: trig = TIMER_OVF_I & q.auto_st;
            default: trig = as_rise;
        endcase
        trig = trig & auto_mode;
    end

    assign auto_go = trig & q.en & ~busy;
    assign rpt_set = trig & busy;
    assign conv_done = busy & q.en & ADC_DONE_I;
    assign grp_end = conv_done & auto_mode & (q.done_n + 6'h01 == target);

    always_comb
    begin
        n = q;
        n.go = 1'b0;
        n.pwm_p = PWM_CH0_I;
        n.ovp_p = OVP_CMP_I;
        // timer start from comparator or auto-start edge
        n.tstart = auto_mode & (
            (q.tsrc == TRG_TMR_OVP & ovp_rise & q.auto_st) |
            (q.tsrc == TRG_TMR_SW & as_rise));
        n.div = q.div + 7'h01;
        n.tick = (q.div & div_mask(q.ctrl1[C1_CKS_MSB:0]))
            == div_mask(q.ctrl1[C1_CKS_MSB:0]);
        if (wr_c0)
        begin
            n.start = PWDATA_I[C0_START];
            n.en = PWDATA_I[C0_EN];
            n.fmt = PWDATA_I[C0_FMT];
            n.ch = PWDATA_I[C0_CH_MSB:0];
        end
        if (wr_c1)
            n.ctrl1 = PWDATA_I[7:0];
        if (wr_c2)
        begin
            n.tsrc = PWDATA_I[C2_TSRC_MSB:C2_TSRC_LSB];
            n.cnt = PWDATA_I[C2_CNT_MSB:0];
            n.done_n = 6'h00;
            n.ch2 = 1'b0;
            // software clears only by writing zero
            if (!PWDATA_I[C2_RPT])
                n.rpt = 1'b0;
        end
        if (n.cnt != 3'h0)
            n.fmt = 1'b1;
        case (q.conv)
            CONV_IDLE:
            begin
                if (manual_go | auto_go)
                begin
                    n.conv = CONV_RUN;
                    n.go = 1'b1;
                end
            end
            CONV_RUN:
            begin
                // disable abandons the conversion, results hold
                if (!q.en)
                    n.conv = CONV_IDLE;
                else if (ADC_DONE_I)
                begin
                    if (q.fmt)
                    begin
                        n.rhi = {4'h0, ADC_DATA_I[11:8]};
                        n.rlo = ADC_DATA_I[7:0];
                    end
                    else
                    begin
                        n.rhi = ADC_DATA_I[11:4];
                        n.rlo = {ADC_DATA_I[3:0], 4'h0};
                    end
                    n.conv = CONV_IDLE;
                    if (auto_mode)
                    begin
                        n.done_n = q.done_n + 6'h01;
                        n.ch2 = two_mode & ~q.ch2;
                    end
                    if (grp_end)
                    begin
                        n.done_n = 6'h00;
                        n.ch2 = 1'b0;
                        n.auto_st = 1'b0;
                    end
                end
            end
            default: n.conv = CONV_IDLE;
        endcase
        if (wr_au)
        begin
            n.auto_st = PWDATA_I[AU_START];
            n.two = PWDATA_I[AU_TWO];
        end
        if (as_rise)
            n.rpt = 1'b0;
        // hardware set wins over any clear
        if (rpt_set)
            n.rpt = 1'b1;
        // read data captured in the setup phase
        if (rd_setup)
        begin
            n.rdata = 32'h0000_0000;
            if (hit_c0)
                n.rdata[7:0] = {q.start, busy, q.en, q.fmt, q.ch};
            else if (hit_c1)
                n.rdata[7:0] = q.ctrl1;
            else if (hit_c2)
                n.rdata[7:0] = {q.tsrc, 1'b0, q.rpt, 1'b0, q.cnt};
            else if (hit_hi)
                n.rdata[7:0] = q.rhi;
            else if (hit_lo)
                n.rdata[7:0] = q.rlo;
            else if (hit_au)
                n.rdata[7:0] = {6'h00, q.two, q.auto_st};
        end
    end

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            q <= '0;
            q.conv <= CONV_IDLE;
            q.start <= RST_CTRL0[C0_START];
            q.en <= RST_CTRL0[C0_EN];
            q.fmt <= RST_CTRL0[C0_FMT];
            q.ch <= RST_CTRL0[C0_CH_MSB:0];
            q.ctrl1 <= RST_CTRL1;
            q.tsrc <= RST_CTRL2[C2_TSRC_MSB:C2_TSRC_LSB];
            q.rpt <= RST_CTRL2[C2_RPT];
            q.cnt <= RST_CTRL2[C2_CNT_MSB:0];
            q.rhi <= RST_RES;
            q.rlo <= RST_RES;
        end
        else if (CLK_EN_I)
            q <= n;
    end

    // input routing
    assign chan_sel = q.ch2 ? CH2_SEL_I : CH1_SEL_I;
    assign ins = q.ctrl1[C1_INS_MSB:C1_INS_LSB];
    assign int_pick = (ins >= 3'h1) & (ins <= 3'h4);

    always_comb
    begin
        asel.int_sig = SIG_BANDGAP;
        asel.ref_int = q.ctrl1[C1_REF_MSB:C1_REF_LSB] == 2'b01;
        if (two_mode)
        begin
            asel.int_on = ~chan_sel[4];
            asel.int_sig = chan_int(chan_sel[3:0]);
            asel.ext_ch = chan_sel[3:0];
        end
        else
        begin
            asel.int_on = int_pick;
            if (int_pick)
                asel.int_sig = int_sig_e'(2'(ins - 3'h1));
            asel.ext_ch = q.ch;
        end
        // external path only for valid codes, no internal pick
        asel.ext_on = ~asel.int_on & (asel.ext_ch <= EXT_CH_LAST);
    end

    assign ANALOG_SEL_O = asel;
    // pin taken over as analog input
    assign PIN_ANALOG_O = asel.ext_on ? 11'(11'h001 << asel.ext_ch)
                                      : 11'h000;

    assign PRDATA_O = q.rdata;
    assign PREADY_O = CLK_EN_I;
    assign PSLVERR_O = acc & ~mapped;
    assign ADC_PWR_O = q.en;
    assign ADC_START_O = q.go;
    assign CONV_CLK_TICK_O = q.tick;
    assign TIMER_START_O = q.tstart;

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    a_manual_start_busy: assert property (
        CLK_EN_I && manual_go |=> busy && ADC_START_O)
        else $error("manual start did not set busy");
    a_start_ignored_auto: assert property (
        CLK_EN_I && auto_mode && !busy && !trig |=>
        !busy && !ADC_START_O)
        else $error("manual start taken in automatic mode");
    a_busy_clears_done: assert property (
        CLK_EN_I && conv_done |=> !busy)
        else $error("busy not cleared at completion");
    a_result_hold_off: assert property (
        CLK_EN_I && !q.en |=> $stable(q.rhi) && $stable(q.rlo))
        else $error("result changed while disabled");
    a_format_left: assert property (
        CLK_EN_I && conv_done && !q.fmt |=>
        q.rhi == $past(ADC_DATA_I[11:4]) && q.rlo[3:0] == 4'h0)
        else $error("left format result wrong");
    a_format_forced: assert property (
        CLK_EN_I && auto_mode |=> q.fmt)
        else $error("format not forced in automatic mode");
    a_ext_disconnect: assert property (
        asel.int_on |-> !asel.ext_on && PIN_ANALOG_O == 11'h000)
        else $error("external path on with internal signal");
    a_repeat_set: assert property (
        CLK_EN_I && rpt_set |=> q.rpt)
        else $error("repeat flag not set");
    a_repeat_sw_set: assert property (
        CLK_EN_I && wr_c2 && !q.rpt && !rpt_set |=> !q.rpt)
        else $error("software set the repeat flag");
    a_repeat_as_clear: assert property (
        CLK_EN_I && as_rise && !rpt_set |=> !q.rpt)
        else $error("repeat flag not cleared on auto start");
    a_reserved_zero: assert property (
        CLK_EN_I && rd_setup && hit_c2 |=>
        PRDATA_O[5] == 1'b0 && PRDATA_O[3] == 1'b0)
        else $error("reserved bits read nonzero");

endmodule // adc_ctrl

// ---- dv/adc_ctrl_tb.sv ----
// adc_ctrl_tb: self-checking bench for the converter control block.
// assumes adc_ctrl and adc_ctrl_pkg compiled first; bench drives all ports.
`timescale 1ns/1ns
module adc_ctrl_tb;
    import adc_ctrl_pkg::*;
    logic clk = '0;
    logic rst = 1'h1;
    logic cen = 1'h1;
    logic psel = '0;
    logic pen = '0;
    logic pwr = '0;
    logic [7:0] padr = '0;
    logic [31:0] pwd = '0;
    logic [31:0] prd;
    logic [3:0] strb = 4'hf;
    logic pready, perr, pwr_o, st_o, tick_o, tmr_o;
    logic done = '0;
    logic pwm = '0;
    logic ovp = '0;
    logic ovf = '0;
    logic [11:0] dat = '0;
    logic [4:0] c1s = 5'h13;
    logic [4:0] c2s = 5'h01;
    analog_sel_s sel;
    logic [10:0] pin;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int mhi = 0;
    int mlo = 0;
    int n;
    logic [31:0] rd;
    logic er, ok, ext;
    logic [2:0] ins;

    always #20 clk = ~clk;

    adc_ctrl i_adc_ctrl (
        .REF_CLK_I(clk), .SYS_RST_I(rst), .CLK_EN_I(cen),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr),
        .PWDATA_I(pwd), .PSTRB_I(strb), .PRDATA_O(prd), .PREADY_O(pready),
        .PSLVERR_O(perr), .ADC_PWR_O(pwr_o), .ADC_START_O(st_o),
        .ADC_DONE_I(done), .ADC_DATA_I(dat), .CONV_CLK_TICK_O(tick_o),
        .PWM_CH0_I(pwm), .OVP_CMP_I(ovp), .TIMER_OVF_I(ovf),
        .TIMER_START_O(tmr_o), .CH1_SEL_I(c1s), .CH2_SEL_I(c2s),
        .ANALOG_SEL_O(sel), .PIN_ANALOG_O(pin)
    );

    task end_sim();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            bad_count = bad_count + 1;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
        end
    endtask

    // apb transfer: setup, then access held until pready
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pen <= 1'h0;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prd;
        er = perr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'h0, a, 32'h0);
        chk(rd, e);
    endtask

    // wait for converter start (w=0) or timer start (w=1) pulse
    task automatic wait_sig(input logic w, input int lim);
        ok = 1'h0;
        for (int k = 0; k < lim && !ok; k++)
        begin
            @(posedge clk);
            ok = w ? (tmr_o === 1'h1) : (st_o === 1'h1);
        end
    endtask

    // converter done pulse with random data; model follows if enabled
    task automatic fin(input logic f, input logic en);
        logic [11:0] d;
        d = 12'($urandom());
        @(posedge clk);
        done <= 1'h1;
        dat <= d;
        @(posedge clk);
        done <= 1'h0;
        dat <= ~d;
        if (en)
        begin
            mhi = f ? d[11:8] : d[11:4];
            mlo = f ? d[7:0] : {d[3:0], 4'h0};
        end
    endtask

    task automatic res();
        rdc(OFF_RES_HI, mhi);
        rdc(OFF_RES_LO, mlo);
    endtask

    task automatic trig(input int ts);
        @(posedge clk);
        if (ts == 0)
            pwm <= 1'h1;
        else
            ovf <= 1'h1;
        @(posedge clk);
        pwm <= 1'h0;
        ovf <= 1'h0;
    endtask

    task automatic wait_tk();
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (tick_o !== 1'h1 && n < 300);
    endtask

    task automatic chksel(input logic e, input logic [3:0] c,
        input logic i, input logic [1:0] s);
        chk(sel.ext_on, e);
        chk(sel.int_on, i);
        chk(pin, e ? 11'h1 << c : 11'h0);
        if (e)
            chk(sel.ext_ch, c);
        if (i)
            chk(sel.int_sig, s);
    endtask

    initial
    begin
        void'($urandom(32'h034ae83b));
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        rdc(OFF_CTRL0, RST_CTRL0);
        rdc(OFF_CTRL1, RST_CTRL1);
        rdc(OFF_CTRL2, RST_CTRL2);
        rdc(OFF_RES_LO, RST_RES);
        xfer(1'h0, 8'h18, 32'h0);
        chk(er, 1'h1);
        chk(rd, 32'h0);
        @(posedge clk);
        cen <= 1'h0;
        @(negedge clk);
        chk(pready, 1'h0);
        @(posedge clk);
        cen <= 1'h1;
        strb <= 4'h0;
        wr(OFF_CTRL1, 8'hff);
        strb <= 4'hf;
        rdc(OFF_CTRL1, 8'h00);
        // manual conversions in both formats
        for (int f = 0; f < 2; f++)
        begin
            wr(OFF_CTRL0, 8'ha3 | (f << 4));
            wr(OFF_CTRL0, 8'h23 | (f << 4));
            wait_sig(1'h0, 4);
            chk(ok, 1'h1);
            rdc(OFF_CTRL0, 8'h63 | (f << 4));
            chk(pwr_o, 1'h1);
            fin(f[0], 1'h1);
            wr(OFF_CTRL0, 8'h63 | (f << 4));
            rdc(OFF_CTRL0, 8'h23 | (f << 4));
            res();
        end
        // disable during a running conversion: aborted, results hold
        wr(OFF_CTRL0, 8'ha3);
        wr(OFF_CTRL0, 8'h23);
        wr(OFF_CTRL0, 8'h03);
        @(negedge clk);
        chk(pwr_o, 1'h0);
        fin(1'h1, 1'h0);
        wr(OFF_RES_HI, 8'hff);
        res();
        rdc(OFF_CTRL0, 8'h03);
        // start bit and format under automatic count
        wr(OFF_CTRL0, 8'h20);
        wr(OFF_CTRL2, 8'h01);
        wr(OFF_CTRL0, 8'ha0);
        wr(OFF_CTRL0, 8'h20);
        wait_sig(1'h0, 6);
        chk(ok, 1'h0);
        rdc(OFF_CTRL0, 8'h30);
        wr(OFF_CTRL2, 8'hff);
        rdc(OFF_CTRL2, 8'hc7);
        // every trigger source
        for (int ts = 0; ts < 4; ts++)
        begin
            wr(OFF_CTRL2, (ts << 6) | 1);
            wr(OFF_AUTO, 32'h1);
            if (ts == 1)
            begin
                @(posedge clk);
                ovp <= 1'h1;
                @(posedge clk);
                ovp <= 1'h0;
            end
            if (ts == 1 || ts == 2)
            begin
                wait_sig(1'h1, 8);
                chk(ok, 1'h1);
            end
            if (ts != 3)
                trig(ts);
            wait_sig(1'h0, 8);
            chk(ok, 1'h1);
            fin(1'h1, 1'h1);
            rdc(OFF_AUTO, 32'h0);
            res();
        end
        // repeat flag: hardware set, software clear, auto-start clear
        wr(OFF_CTRL2, 8'h01);
        for (int r = 0; r < 2; r++)
        begin
            wr(OFF_AUTO, 32'h1);
            trig(0);
            wait_sig(1'h0, 6);
            trig(0);
            rdc(OFF_CTRL2, 8'h11);
            fin(1'h1, 1'h1);
            if (r == 0)
            begin
                wr(OFF_CTRL2, 8'h01);
                rdc(OFF_CTRL2, 8'h01);
            end
        end
        wr(OFF_AUTO, 32'h1);
        rdc(OFF_CTRL2, 8'h01);
        wr(OFF_AUTO, 32'h0);
        // group sizes for every nonzero count code
        for (int c = 1; c < 8; c++)
        begin
            wr(OFF_CTRL2, c);
            wr(OFF_AUTO, 32'h1);
            n = (c < 5) ? (1 << (c - 1)) : 16;
            for (int k = 0; k < n; k++)
            begin
                rdc(OFF_AUTO, 32'h1);
                trig(0);
                wait_sig(1'h0, 6);
                chk(ok, 1'h1);
                fin(1'h1, 1'h1);
            end
            rdc(OFF_AUTO, 32'h0);
        end
        res();
        // two-channel group alternates the channel selects
        wr(OFF_CTRL2, 8'h01);
        wr(OFF_AUTO, 32'h3);
        for (int k = 0; k < 2; k++)
        begin
            trig(0);
            wait_sig(1'h0, 6);
            chk(ok, 1'h1);
            if (k == 0)
                chksel(1'h1, 4'h3, 1'h0, 2'h0);
            else
                chksel(1'h0, 4'h0, 1'h1, SIG_AMP_A);
            fin(1'h1, 1'h1);
        end
        rdc(OFF_AUTO, 32'h2);
        wr(OFF_AUTO, 32'h0);
        wr(OFF_CTRL2, 8'h00);
        // input, channel and reference routing
        for (int i = 0; i < 128; i++)
        begin
            wr(OFF_CTRL0, 8'h20 | i[3:0]);
            wr(OFF_CTRL1, {i[6:4], i[1:0], 3'h0});
            @(negedge clk);
            ins = i[6:4];
            ext = (ins == 3'h0 || ins > 3'h4);
            chksel(ext && i[3:0] <= EXT_CH_LAST, i[3:0], !ext,
                2'(ins - 3'h1));
            chk(sel.ref_int, i[1:0] == 2'h1);
        end
        // conversion clock divider
        for (int c = 0; c < 8; c++)
        begin
            wr(OFF_CTRL1, c);
            wait_tk();
            wait_tk();
            wait_tk();
            chk(n, 1 << c);
        end
        end_sim();
    end
endmodule // adc_ctrl_tb
